// ---- include/pctr_cfg.svh ----
`ifndef PCTR_CFG_SVH
`define PCTR_CFG_SVH

`define PCTR_AW            12
`define PCTR_OFF_PMC       12'h0DC
`define PCTR_OFF_PMCS      12'h0E0
`define PCTR_OFF_HS        12'h0E4
`define PCTR_OFF_VPD       12'h0E8
`define PCTR_OFF_PRODUCT_DATA_WORD  12'h0EC
`define PCTR_OFF_TW0_CTL   12'h100
`define PCTR_OFF_TW0_ADD   12'h104

`define PCTR_CAPABILITY_IDENTIFIER_PM     8'h01
`define PCTR_CAPABILITY_IDENTIFIER_HS     8'h06
`define PCTR_CAPABILITY_IDENTIFIER_VPD    8'h03
`define PCTR_NEXT_HS       8'hE4
`define PCTR_NEXT_VPD      8'hE8
`define PCTR_NEXT_END      8'h00
`define PCTR_PM_VERSION    3'h1
`define PCTR_WAKE_WMASK    5'h09

`define PCTR_PWR_D0        2'h0
`define PCTR_PWR_D3HOT     2'h3

`define PCTR_PTR_LSB       8
`define PCTR_PMC_SUP_LSB   27
`define PCTR_PMC_DSI       21
`define PCTR_PMC_CLK       19
`define PCTR_PMC_VER_LSB   16
`define PCTR_PMCS_ST       15
`define PCTR_PMCS_EN       8
`define PCTR_HS_INS        23
`define PCTR_HS_EXT        22
`define PCTR_HS_LED        19
`define PCTR_HS_EIM        17
`define PCTR_VPD_FLAG      31
`define PCTR_PRODUCT_DATA_ADDRESS_LSB  16
`define PCTR_CTL_EN        31
`define PCTR_CTL_BS_LSB    24
`define PCTR_CTL_PREFETCH_READ_ENABLE      23
`define PCTR_CTL_BRST      22
`define PCTR_CTL_INV       19
`define PCTR_CTL_TC_LSB    12
`define PCTR_CTL_DSZ_LSB   10
`define PCTR_CTL_POSTED_WRITE_ENABLE      7
`define PCTR_CTL_PAS       6
`define PCTR_ADD_BA_LSB    16
`define PCTR_LANE_FLAG     3
`define PCTR_LANE_ADDR     2
`define PCTR_WORD_ALIGN    2'h0
`define PCTR_MASK_ALL      16'hFFFF

`endif

// ---- include/pctr_pkg.sv ----
package pctr_pkg;
	typedef enum logic [1:0] {PCTR_VPD_IDLE, PCTR_VPD_WRITE, PCTR_VPD_READ} pctr_vpd_e;
	typedef logic [1:0]  pctr_pwr_t;
	typedef logic [3:0]  pctr_bs_t;
	typedef logic [15:0] pctr_hi_t;
endpackage : pctr_pkg

// ---- logic/pctr_cap_regs.sv ----
`include "pctr_cfg.svh"

//Contract
//RULE1 - wake support field: bit0 means wake from D0, bit3 from D3hot, others zero.
//RULE2 - state2, state1 support and aux power source read as zero.
//RULE3 - wake clock bit reads one exactly when any wake support bit is set.
//RULE4 - power capability reads version 001, next pointer E4, identifier 01.
//RULE5 - power state reads current state; only D0 and D3hot writes take effect.
//RULE6 - wake status sets on every wake event, clears on write one; PME# needs enable.
//RULE7 - insertion status sets when EEPROM load ends with disable option clear; W1C.
//RULE8 - extraction status sets on ejector switch high outside PCI reset; W1C.
//RULE9 - read-write LED bit and enumeration interrupt mask bit, both reset zero.
//RULE10 - hot swap identifier 06; next pointer E8 with product data, else 00.
//RULE11 - flag written one writes data word to EEPROM, flag clears when done.
//RULE12 - flag written zero reads EEPROM word into data, flag sets when done.
//RULE13 - product data address is word aligned, resets zero, low byte at address.
//RULE14 - product data capability reads identifier 03 and next pointer 00.
//RULE15 - host loads data before write start; read data valid once flag is one.
//RULE16 - image, prefetch, burst, posted enables reset zero; posting memory space only.
//RULE17 - endian invert flips local byte order; transaction code user field reset zero.
//RULE18 - destination width 00 is 32, 01 is 8, 10 is 16 bits.
//RULE19 - EEPROM-loaded block size and space are read only; space mirrors base register.
//RULE20 - unloaded fields reset zero, writable, base register off; disable option keeps local write. Code: option set turns base register on.
//RULE21 - window is 64K times two to block size; code masks low compared lines.
//RULE22 - compared lines replaced by translation bits when forming the local address.
//RULE23 - ENUM# driven while any hot swap status set and mask clear.
module pctr_cap_regs (
	input  wire logic                 ref_clk,
	input  wire logic                 resetn,
	input  wire logic                 pci_rst_n_pin,
	input  wire logic                 reg_rd,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_local,
	input  wire logic [`PCTR_AW-1:0]  reg_addr,
	input  wire logic [3:0]           reg_be,
	input  wire logic [31:0]          reg_wdata,
	output logic [31:0]               reg_rdata,
	output logic                      reg_rvalid,
	input  wire logic                 wake_event,
	output logic                      pme_n_o,
	output logic                      pme_n_oe,
	input  wire logic                 ejector_switch_input,
	output logic                      enum_n_o,
	output logic                      enum_n_oe,
	output logic                      blue_led_on,
	input  wire logic                 host_bus_disable_option,
	input  wire logic                 ee_load_done,
	input  wire logic                 ee_fields_loaded,
	input  wire pctr_pkg::pctr_bs_t   ee_block_size,
	input  wire logic                 ee_address_space,
	input  wire logic                 vpd_enable,
	input  wire pctr_pkg::pctr_hi_t   bst0_base,
	input  wire logic                 bst0_address_space,
	output logic                      ee_req,
	output logic                      ee_we,
	output logic [7:0]                ee_addr,
	output logic [31:0]               ee_wdata,
	input  wire logic                 ee_done,
	input  wire logic [31:0]          ee_rdata,
	input  wire logic                 local_byte_order,
	input  wire logic [31:0]          pci_addr,
	output logic                      image_enable,
	output logic                      prefetch_read_enable,
	output logic                      burst_write_enable,
	output logic                      posted_write_allowed,
	output logic                      byte_order_eff,
	output logic [3:0]                local_transaction_code,
	output logic [1:0]                destination_port_width,
	output pctr_pkg::pctr_bs_t        block_size_code,
	output logic                      address_space_select,
	output logic                      base_bar_disable,
	output logic                      xlate_hit,
	output logic [31:0]               xlate_addr
);
	import pctr_pkg::*;

	function automatic logic [31:0] lane_mask(input logic [3:0] be);
		lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : lane_mask

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [31:0] m);
		merge = (old_v & ~m) | (new_v & m);
	endfunction : merge

	// one more low address line is dropped for each step of the code
	function automatic pctr_hi_t cmp_mask(input pctr_bs_t bs);
		cmp_mask = `PCTR_MASK_ALL << bs;
	endfunction : cmp_mask

	logic        pci_rst_meta, pci_rst_sync;
	logic        sw_meta, sw_sync;
	logic        opt_meta, opt_sync, opt_reg;
	logic        ld_prev, ee_loaded_reg;
	logic [4:0]  wake_support_states;
	logic        dsi_reg;
	logic        wake_status, wake_enable;
	pctr_pwr_t   power_state;
	logic        insertion_status, extraction_status;
	logic        blue_led_reg, enumeration_irq_mask;
	logic        product_data_flag;
	logic [7:0]  product_data_address;
	logic [31:0] product_data_word;
	pctr_vpd_e   vpd_state;
	logic        en_reg, prefetch_read_enable_reg, brst_reg, inv_reg, posted_write_enable_reg, pas_reg;
	pctr_bs_t    bs_reg;
	logic [3:0]  tc_reg;
	logic [1:0]  dsz_reg;
	pctr_hi_t    ba_reg, ta_reg;
	logic        pin_low_reg;

	logic        pci_clr, ld_rise, mirror, bs_wr_ok;
	logic [31:0] wm, rd_word, add_word;
	pctr_hi_t    base_eff, mask_eff;
	logic        pas_eff;

	assign pci_clr  = !pci_rst_sync;
	assign ld_rise  = ee_load_done && !ld_prev;
	assign wm       = lane_mask(reg_be);
	assign mirror   = ee_loaded_reg || opt_reg;
	// strap keeps local write access even over EEPROM values
	assign bs_wr_ok = !ee_loaded_reg || (opt_reg && reg_local); // RULE19 RULE20
	assign base_eff = mirror ? bst0_base : ba_reg;
	assign pas_eff  = (ee_loaded_reg && !opt_reg) ? bst0_address_space : pas_reg; // RULE19
	assign mask_eff = cmp_mask(bs_reg);
	assign add_word = merge({ba_reg, ta_reg}, reg_wdata, wm);

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pci_rst_meta <= 1'b0;
			pci_rst_sync <= 1'b0;
			sw_meta      <= 1'b0;
			sw_sync      <= 1'b0;
			opt_meta     <= 1'b0;
			opt_sync     <= 1'b0;
		end else begin
			pci_rst_meta <= pci_rst_n_pin;
			pci_rst_sync <= pci_rst_meta;
			sw_meta      <= ejector_switch_input;
			sw_sync      <= sw_meta;
			opt_meta     <= host_bus_disable_option;
			opt_sync     <= opt_meta;
		end
	end

	// strap caught while PCI reset is held, frozen after release
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			opt_reg       <= 1'b0;
			ld_prev       <= 1'b0;
			ee_loaded_reg <= 1'b0;
		end else begin
			ld_prev <= ee_load_done;
			if (pci_clr) begin
				opt_reg       <= opt_sync;
				ee_loaded_reg <= 1'b0;
			end else if (ld_rise) begin
				ee_loaded_reg <= ee_fields_loaded;
			end
		end
	end

	// power management capability: only DSI and the D0 and D3hot support bits are writable
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wake_support_states <= 5'h00;
			dsi_reg             <= 1'b0;
		end else if (pci_clr) begin
			wake_support_states <= 5'h00;
			dsi_reg             <= 1'b0;
		end else if (reg_wr && reg_local && reg_addr == `PCTR_OFF_PMC && reg_be[3]) begin
			wake_support_states <= reg_wdata[`PCTR_PMC_SUP_LSB +: 5] & `PCTR_WAKE_WMASK; // RULE1
			dsi_reg             <= reg_wdata[`PCTR_PMC_DSI] & reg_be[2];
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wake_enable <= 1'b0;
			power_state <= `PCTR_PWR_D0;
		end else if (pci_clr) begin
			wake_enable <= 1'b0;
			power_state <= `PCTR_PWR_D0;
		end else if (reg_wr && reg_addr == `PCTR_OFF_PMCS) begin
			if (reg_be[1])
				wake_enable <= reg_wdata[`PCTR_PMCS_EN];
			// unimplemented states complete but change nothing
			if (reg_be[0] && (reg_wdata[1:0] == `PCTR_PWR_D0 || reg_wdata[1:0] == `PCTR_PWR_D3HOT))
				power_state <= reg_wdata[1:0]; // RULE5
		end
	end

	// set beats a same-cycle write-one clear so no event is lost
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			wake_status <= 1'b0;
		end else if (pci_clr) begin
			wake_status <= 1'b0;
		end else if (wake_event) begin
			wake_status <= 1'b1; // RULE6
		end else if (reg_wr && reg_addr == `PCTR_OFF_PMCS && wm[`PCTR_PMCS_ST]
			&& reg_wdata[`PCTR_PMCS_ST]) begin
			wake_status <= 1'b0; // RULE6
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			insertion_status  <= 1'b0;
			extraction_status <= 1'b0;
		end else if (pci_clr) begin
			insertion_status  <= 1'b0;
			extraction_status <= 1'b0;
		end else begin
			if (ld_rise && !opt_reg)
				insertion_status <= 1'b1; // RULE7
			else if (reg_wr && reg_addr == `PCTR_OFF_HS && wm[`PCTR_HS_INS] && reg_wdata[`PCTR_HS_INS])
				insertion_status <= 1'b0; // RULE7
			if (sw_sync)
				extraction_status <= 1'b1; // RULE8
			else if (reg_wr && reg_addr == `PCTR_OFF_HS && wm[`PCTR_HS_EXT] && reg_wdata[`PCTR_HS_EXT])
				extraction_status <= 1'b0; // RULE8
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			blue_led_reg         <= 1'b0;
			enumeration_irq_mask <= 1'b0;
		end else if (pci_clr) begin
			blue_led_reg         <= 1'b0;
			enumeration_irq_mask <= 1'b0;
		end else if (reg_wr && reg_addr == `PCTR_OFF_HS && reg_be[2]) begin
			blue_led_reg         <= reg_wdata[`PCTR_HS_LED]; // RULE9
			enumeration_irq_mask <= reg_wdata[`PCTR_HS_EIM]; // RULE9
		end
	end

	// product data access; a new flag write while busy is dropped
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			vpd_state            <= PCTR_VPD_IDLE;
			product_data_flag    <= 1'b0;
			product_data_address <= 8'h00;
			ee_req               <= 1'b0;
			ee_we                <= 1'b0;
			ee_addr              <= 8'h00;
		end else if (pci_clr) begin
			vpd_state            <= PCTR_VPD_IDLE;
			product_data_flag    <= 1'b0;
			product_data_address <= 8'h00;
			ee_req               <= 1'b0;
			ee_we                <= 1'b0;
			ee_addr              <= 8'h00;
		end else begin
			unique case (vpd_state)
				PCTR_VPD_IDLE: begin
					if (reg_wr && reg_addr == `PCTR_OFF_VPD) begin
						if (reg_be[`PCTR_LANE_ADDR])
							product_data_address <= {reg_wdata[`PCTR_PRODUCT_DATA_ADDRESS_LSB+2 +: 6], `PCTR_WORD_ALIGN}; // RULE13
						if (reg_be[`PCTR_LANE_FLAG]) begin
							product_data_flag <= reg_wdata[`PCTR_VPD_FLAG];
							ee_req            <= 1'b1;
							ee_we             <= reg_wdata[`PCTR_VPD_FLAG];
							ee_addr           <= reg_be[`PCTR_LANE_ADDR]
								? {reg_wdata[`PCTR_PRODUCT_DATA_ADDRESS_LSB+2 +: 6], `PCTR_WORD_ALIGN}
								: product_data_address;
							vpd_state         <= reg_wdata[`PCTR_VPD_FLAG] ? PCTR_VPD_WRITE : PCTR_VPD_READ;
						end
					end
				end
				PCTR_VPD_WRITE: begin
					if (ee_done) begin
						ee_req            <= 1'b0;
						product_data_flag <= 1'b0; // RULE11
						vpd_state         <= PCTR_VPD_IDLE;
					end
				end
				PCTR_VPD_READ: begin
					if (ee_done) begin
						ee_req            <= 1'b0;
						product_data_flag <= 1'b1; // RULE12
						vpd_state         <= PCTR_VPD_IDLE;
					end
				end
			endcase
		end
	end

	// data stays host writable during a read; the EEPROM result overrides it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			product_data_word <= 32'h0000_0000;
		end else if (pci_clr) begin
			product_data_word <= 32'h0000_0000;
		end else if (vpd_state == PCTR_VPD_READ && ee_done) begin
			product_data_word <= ee_rdata; // RULE12
		end else if (reg_wr && reg_addr == `PCTR_OFF_PRODUCT_DATA_WORD) begin
			product_data_word <= merge(product_data_word, reg_wdata, wm);
		end
	end

	// fields kept only by the general reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			en_reg   <= 1'b0;
			prefetch_read_enable_reg <= 1'b0;
			brst_reg <= 1'b0;
			inv_reg  <= 1'b0;
			tc_reg   <= 4'h0;
			dsz_reg  <= 2'h0;
			posted_write_enable_reg <= 1'b0;
			ta_reg   <= 16'h0000;
		end else if (reg_wr && reg_addr == `PCTR_OFF_TW0_CTL) begin
			if (reg_be[3])
				en_reg <= reg_wdata[`PCTR_CTL_EN]; // RULE16
			if (reg_be[2]) begin
				prefetch_read_enable_reg <= reg_wdata[`PCTR_CTL_PREFETCH_READ_ENABLE]; // RULE16
				brst_reg <= reg_wdata[`PCTR_CTL_BRST]; // RULE16
				inv_reg  <= reg_wdata[`PCTR_CTL_INV]; // RULE17
			end
			if (reg_be[1]) begin
				tc_reg  <= reg_wdata[`PCTR_CTL_TC_LSB +: 4]; // RULE17
				dsz_reg <= reg_wdata[`PCTR_CTL_DSZ_LSB +: 2]; // RULE18
			end
			if (reg_be[0])
				posted_write_enable_reg <= reg_wdata[`PCTR_CTL_POSTED_WRITE_ENABLE]; // RULE16
		end else if (reg_wr && reg_addr == `PCTR_OFF_TW0_ADD) begin
			ta_reg <= add_word[15:0]; // RULE22
		end
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			bs_reg  <= 4'h0;
			pas_reg <= 1'b0;
			ba_reg  <= 16'h0000;
		end else if (pci_clr) begin
			bs_reg  <= 4'h0; // RULE20
			pas_reg <= 1'b0; // RULE20
			ba_reg  <= 16'h0000;
		end else if (ld_rise && ee_fields_loaded) begin
			bs_reg  <= ee_block_size; // RULE19
			pas_reg <= ee_address_space; // RULE19
		end else if (reg_wr && reg_addr == `PCTR_OFF_TW0_CTL && bs_wr_ok) begin
			if (reg_be[3])
				bs_reg <= reg_wdata[`PCTR_CTL_BS_LSB +: 4]; // RULE20
			if (reg_be[0])
				pas_reg <= reg_wdata[`PCTR_CTL_PAS]; // RULE20
		end else if (reg_wr && reg_addr == `PCTR_OFF_TW0_ADD && !mirror) begin
			ba_reg <= add_word[31:16];
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (reg_addr)
			`PCTR_OFF_PMC: begin
				rd_word[`PCTR_PMC_SUP_LSB +: 5]   = wake_support_states; // RULE1 RULE2
				rd_word[`PCTR_PMC_DSI]            = dsi_reg;
				rd_word[`PCTR_PMC_CLK]            = |wake_support_states; // RULE3
				rd_word[`PCTR_PMC_VER_LSB +: 3]   = `PCTR_PM_VERSION; // RULE4
				rd_word[`PCTR_PTR_LSB +: 8]       = `PCTR_NEXT_HS; // RULE4
				rd_word[7:0]                      = `PCTR_CAPABILITY_IDENTIFIER_PM; // RULE4
			end
			`PCTR_OFF_PMCS: begin
				rd_word[`PCTR_PMCS_ST] = wake_status;
				rd_word[`PCTR_PMCS_EN] = wake_enable;
				rd_word[1:0]           = power_state; // RULE5
			end
			`PCTR_OFF_HS: begin
				rd_word[`PCTR_HS_INS]       = insertion_status;
				rd_word[`PCTR_HS_EXT]       = extraction_status;
				rd_word[`PCTR_HS_LED]       = blue_led_reg;
				rd_word[`PCTR_HS_EIM]       = enumeration_irq_mask;
				rd_word[`PCTR_PTR_LSB +: 8] = vpd_enable ? `PCTR_NEXT_VPD : `PCTR_NEXT_END; // RULE10
				rd_word[7:0]                = `PCTR_CAPABILITY_IDENTIFIER_HS; // RULE10
			end
			`PCTR_OFF_VPD: begin
				rd_word[`PCTR_VPD_FLAG]               = product_data_flag; // RULE15
				rd_word[`PCTR_PRODUCT_DATA_ADDRESS_LSB +: 8]      = product_data_address;
				rd_word[`PCTR_PTR_LSB +: 8]           = `PCTR_NEXT_END; // RULE14
				rd_word[7:0]                          = `PCTR_CAPABILITY_IDENTIFIER_VPD; // RULE14
			end
			`PCTR_OFF_PRODUCT_DATA_WORD: rd_word = product_data_word;
			`PCTR_OFF_TW0_CTL: begin
				rd_word[`PCTR_CTL_EN]             = en_reg;
				rd_word[`PCTR_CTL_BS_LSB +: 4]    = bs_reg;
				rd_word[`PCTR_CTL_PREFETCH_READ_ENABLE]           = prefetch_read_enable_reg;
				rd_word[`PCTR_CTL_BRST]           = brst_reg;
				rd_word[`PCTR_CTL_INV]            = inv_reg;
				rd_word[`PCTR_CTL_TC_LSB +: 4]    = tc_reg;
				rd_word[`PCTR_CTL_DSZ_LSB +: 2]   = dsz_reg;
				rd_word[`PCTR_CTL_POSTED_WRITE_ENABLE]           = posted_write_enable_reg;
				rd_word[`PCTR_CTL_PAS]            = pas_eff;
			end
			`PCTR_OFF_TW0_ADD: rd_word = {base_eff, ta_reg};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata  <= 32'h0000_0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
				reg_rdata <= rd_word;
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pin_low_reg <= 1'b0;
			pme_n_oe    <= 1'b0;
			enum_n_oe   <= 1'b0;
			blue_led_on <= 1'b0;
		end else begin
			pin_low_reg <= 1'b0;
			pme_n_oe    <= wake_status && wake_enable; // RULE6
			enum_n_oe   <= (insertion_status || extraction_status) && !enumeration_irq_mask; // RULE23
			blue_led_on <= blue_led_reg; // RULE9
		end
	end
	assign pme_n_o  = pin_low_reg;
	assign enum_n_o = pin_low_reg;
	assign ee_wdata = product_data_word; // RULE15

	// decode controls and the registered address compare and translate
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			image_enable           <= 1'b0;
			prefetch_read_enable   <= 1'b0;
			burst_write_enable     <= 1'b0;
			posted_write_allowed   <= 1'b0;
			byte_order_eff         <= 1'b0;
			local_transaction_code <= 4'h0;
			destination_port_width <= 2'h0;
			block_size_code        <= 4'h0;
			address_space_select   <= 1'b0;
			base_bar_disable       <= 1'b1;
			xlate_hit              <= 1'b0;
			xlate_addr             <= 32'h0000_0000;
		end else begin
			image_enable           <= en_reg;
			prefetch_read_enable   <= prefetch_read_enable_reg;
			burst_write_enable     <= brst_reg;
			posted_write_allowed   <= posted_write_enable_reg && !pas_eff; // RULE16
			byte_order_eff         <= local_byte_order ^ inv_reg; // RULE17
			local_transaction_code <= tc_reg;
			destination_port_width <= dsz_reg; // RULE18
			block_size_code        <= bs_reg;
			address_space_select   <= pas_eff;
			base_bar_disable       <= !mirror; // RULE20
			xlate_hit              <= en_reg && (((pci_addr[31:16] ^ base_eff) & mask_eff) == 16'h0000); // RULE21
			xlate_addr             <= {(ta_reg & mask_eff) | (pci_addr[31:16] & ~mask_eff), pci_addr[15:0]}; // RULE22
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	wake_clock_a: assert property (reg_rd && reg_addr == `PCTR_OFF_PMC |=> // RULE3
		reg_rdata[`PCTR_PMC_CLK] == (|reg_rdata[`PCTR_PMC_SUP_LSB +: 5]))
		else $error("wake clock bit disagrees with support bits");
	wake_support_a: assert property ((wake_support_states & ~`PCTR_WAKE_WMASK) == 5'h00) // RULE1
		else $error("unsupported wake state bit set");
	pm_header_a: assert property (reg_rd && reg_addr == `PCTR_OFF_PMC |=> // RULE4
		reg_rdata[15:0] == {`PCTR_NEXT_HS, `PCTR_CAPABILITY_IDENTIFIER_PM} && reg_rdata[26:25] == 2'h0)
		else $error("power capability header wrong");
	power_state_a: assert property (power_state == `PCTR_PWR_D0 || power_state == `PCTR_PWR_D3HOT) // RULE5
		else $error("illegal power state held");
	wake_set_a: assert property (wake_event && !pci_clr |=> wake_status ##1 pme_n_oe == $past(wake_enable)) // RULE6
		else $error("wake event lost or pin wrong");
	enum_drive_a: assert property (##1 enum_n_oe == $past((insertion_status || extraction_status) // RULE23
		&& !enumeration_irq_mask))
		else $error("enum pin not following status");
	vpd_write_a: assert property (vpd_state == PCTR_VPD_WRITE && ee_done && !pci_clr |=> // RULE11
		!product_data_flag && !ee_req)
		else $error("write completion flag wrong");
	vpd_read_a: assert property (vpd_state == PCTR_VPD_READ && ee_done && !pci_clr |=> // RULE12
		product_data_flag && product_data_word == $past(ee_rdata))
		else $error("read completion wrong");
	hs_next_a: assert property (reg_rd && reg_addr == `PCTR_OFF_HS |=> // RULE10
		reg_rdata[15:8] == ($past(vpd_enable) ? `PCTR_NEXT_VPD : `PCTR_NEXT_END))
		else $error("hot swap next pointer wrong");
	vpd_align_a: assert property (product_data_address[1:0] == `PCTR_WORD_ALIGN) // RULE13
		else $error("product data address not aligned");
	xlate_form_a: assert property (##1 xlate_addr[15:0] == $past(pci_addr[15:0])) // RULE22
		else $error("untranslated low address altered");
endmodule : pctr_cap_regs

// ---- sim/pctr_ee_model.sv ----
module pctr_ee_model (
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	input  wire logic        ee_req,
	input  wire logic        ee_we,
	input  wire logic [7:0]  ee_addr,
	input  wire logic [31:0] ee_wdata,
	output logic             ee_done,
	output logic [31:0]      ee_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] mem_reg [64];
	int          wait_cnt;
	// latency grows with address bits 5:2, so both prompt and slow answers occur
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ee_done <= 1'b0;
			wait_cnt <= 0;
			ee_rdata <= 32'h0;
			for (int i = 0; i < 64; i++) mem_reg[i] <= 32'hC0DE0000 + i;
		end else begin
			ee_done <= 1'b0;
			ee_rdata <= ~ee_rdata; // data not valid outside the answer cycle
			if (ee_req && !ee_done) begin
				if (wait_cnt == 1 + 3 * ee_addr[5:2]) begin
					ee_done <= 1'b1;
					wait_cnt <= 0;
					if (ee_we) mem_reg[ee_addr[7:2]] <= ee_wdata;
					else ee_rdata <= mem_reg[ee_addr[7:2]];
				end else wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule : pctr_ee_model

// ---- sim/tb.sv ----
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pctr_pkg::*;
	logic        ref_clk = 0, resetn = 0, reg_rd = 0, reg_wr = 0, reg_local = 0, wake_event = 0;
	logic        ejector_switch_input = 0, ee_load_done = 0, vpd_enable = 1, local_byte_order = 0;
	logic        pci_rst_n_pin = 1, host_bus_disable_option = 0;
	logic [11:0] reg_addr = 0;
	logic [31:0] reg_wdata = 0, pci_addr = 0, ee_rdata, reg_rdata, ee_wdata, xlate_addr;
	logic        reg_rvalid, pme_n_o, pme_n_oe, enum_n_o, enum_n_oe, blue_led_on, ee_req, ee_we, ee_done;
	logic        image_enable, prefetch_read_enable, burst_write_enable, posted_write_allowed, byte_order_eff;
	logic        address_space_select, base_bar_disable, xlate_hit;
	logic [7:0]  ee_addr;
	logic [3:0]  local_transaction_code, reg_be = 4'hF;
	logic [1:0]  destination_port_width;
	pctr_bs_t    block_size_code;
	int          bad_count = 0, comparisons = 0;
	always #4 ref_clk = ~ref_clk;
	pctr_cap_regs u_pctr_cap_regs (.*, .ee_fields_loaded(1'b0), .ee_block_size(4'h0), .ee_address_space(1'b0),
		.bst0_base(16'h0), .bst0_address_space(1'b0));
	pctr_ee_model u_pctr_ee_model (.*);
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic l);
		@(posedge ref_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= d;
		reg_local <= l;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1;
	endtask : acc
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic l = 1'b0);
		acc(1'b1, a, d, l);
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
		acc(1'b0, a, 32'h0, 1'b0);
		chk(reg_rvalid, 1'b1);
		chk(reg_rdata & m, e & m);
	endtask : rd
	task automatic pulse_wake;
		@(posedge ref_clk);
		wake_event <= 1'b1;
		@(posedge ref_clk);
		wake_event <= 1'b0;
		tick(1);
	endtask : pulse_wake
	task automatic wait_flag(input logic v);
		for (int i = 0; i < 60; i++) begin
			acc(1'b0, 12'h0E8, 32'h0, 1'b0);
			if (reg_rdata[31] === v) return;
		end
		chk(reg_rdata[31], v);
		complete_run();
	endtask : wait_flag
	task automatic t_caps;
		rd(12'h0DC, 32'h0001E401, 32'hFFFFFFFF);
		wr(12'h0DC, 32'hFFFFFFFF, 1'b1);
		rd(12'h0DC, 32'h4809E401, 32'hFFDFFFFF);
		rd(12'h0E8, 32'h00000003, 32'hFFFFFFFF);
		$display("test caps done");
	endtask : t_caps
	task automatic t_power;
		for (int i = 3; i >= 0; i--) begin
			wr(12'h0E0, i);
			rd(12'h0E0, (i == 0) ? 32'h0 : 32'h3, 32'h3);
		end
		$display("test power done");
	endtask : t_power
	task automatic t_wake;
		pulse_wake();
		chk(pme_n_oe, 1'b0);
		rd(12'h0E0, 32'h8000, 32'h8000);
		wr(12'h0E0, 32'h8000);
		rd(12'h0E0, 32'h0, 32'h8000);
		wr(12'h0E0, 32'h0100);
		pulse_wake();
		chk(pme_n_oe, 1'b1);
		chk({pme_n_o, enum_n_o}, 2'b00);
		$display("test wake done");
	endtask : t_wake
	task automatic t_hs;
		rd(12'h0E4, 32'h0080E806, 32'h00CAFFFF);
		chk(enum_n_oe, 1'b1);
		wr(12'h0E4, 32'h00800000);
		tick(1);
		chk(enum_n_oe, 1'b0);
		wr(12'h0E4, 32'h000A0000);
		ejector_switch_input <= 1'b1;
		tick(5);
		chk(blue_led_on, 1'b1);
		rd(12'h0E4, 32'h004A0000, 32'h00CA0000);
		chk(enum_n_oe, 1'b0);
		vpd_enable <= 1'b0;
		rd(12'h0E4, 32'h00000006, 32'h0000FFFF);
		$display("test hot swap done");
	endtask : t_hs
	task automatic t_vpd;
		wr(12'h0E8, 32'h00090000);
		wait_flag(1'b1);
		rd(12'h0EC, 32'hC0DE0002, 32'hFFFFFFFF);
		rd(12'h0E8, 32'h80080003, 32'hFFFFFFFF);
		wr(12'h0EC, 32'h12345678);
		wr(12'h0E8, 32'h80100000);
		wait_flag(1'b0);
		wr(12'h0E8, 32'h00100000);
		wait_flag(1'b1);
		rd(12'h0EC, 32'h12345678, 32'hFFFFFFFF);
		$display("test product data done");
	endtask : t_vpd
	task automatic t_img;
		chk(base_bar_disable, 1'b1);
		wr(12'h100, 32'h81C8A480);
		wr(12'h104, 32'h1234ABCD);
		tick(1);
		chk({image_enable, prefetch_read_enable, burst_write_enable, posted_write_allowed,
			byte_order_eff, local_transaction_code, destination_port_width, block_size_code,
			address_space_select}, 16'hFD22);
		rd(12'h100, 32'h81C8A480, 32'hFFFFFFFF);
		local_byte_order <= 1'b1;
		pci_addr <= 32'h12356789;
		tick(3);
		chk(byte_order_eff, 1'b0);
		chk({xlate_hit, xlate_addr}, {1'b1, 32'hABCD6789});
		pci_addr <= 32'h12376789;
		tick(3);
		chk(xlate_hit, 1'b0);
		$display("test target image done");
	endtask : t_img
	task automatic t_prst;
		wr(12'h0E0, 32'h3);
		pci_rst_n_pin <= 1'b0;
		host_bus_disable_option <= 1'b1;
		tick(4);
		rd(12'h0E0, 32'h0, 32'h3);
		rd(12'h0E4, 32'h0, 32'h00C00000);
		chk({image_enable, block_size_code}, 5'h10);
		pci_rst_n_pin <= 1'b1;
		tick(4);
		chk(base_bar_disable, 1'b0);
		rd(12'h0E4, 32'h00400000, 32'h00C00000);
		reg_be <= 4'h1;
		wr(12'h100, 32'h0);
		reg_be <= 4'hF;
		rd(12'h100, 32'h80C8A400, 32'hFFFFFFFF);
		$display("test pci reset done");
	endtask : t_prst
	initial begin
		repeat (4) @(posedge ref_clk);
		resetn <= 1'b1;
		tick(3);
		ee_load_done <= 1'b1;
		tick(3);
		t_caps();
		t_power();
		t_wake();
		t_hs();
		t_vpd();
		t_img();
		t_prst();
		complete_run();
	end
endmodule : tb
